// *** core/clock_gen_smbus_control_regs.sv ***
`timescale 1ns/1ps
`include "clock_gen_defines.svh"
module clock_gen_smbus_control_regs #(
	parameter logic [6:0] BUS_ADDR = `DEFAULT_BUS_ADDR,
	parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
	parameter logic [3:0] MAKER_CODE = 4'h9, // arbitrary value
	parameter logic [1:0] PART_TYPE = 2'b11, // arbitrary value
	parameter logic [5:0] PART_IDENTIFIER = 6'h15 // arbitrary value
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe_n,
	input wire logic [7:0] diff_oe_pin_n,
	input wire logic [1:0] spread_strap_level,
	output clock_gen_pkg::clock_cfg_t clock_cfg
);
	logic [11:0] lvl, lvl_d;
	line_sync #(.WIDTH(12)) line_sync_i (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({spread_strap_level, diff_oe_pin_n, smb_data_in, smb_clk}),
		.level(lvl),
		.level_d(lvl_d)
	);
	logic scl, sda, scl_rise, scl_fall, start_seen, stop_seen;
	assign scl = lvl[0];
	assign sda = lvl[1];
	assign scl_rise = scl & ~lvl_d[0];
	assign scl_fall = ~scl & lvl_d[0];
	assign start_seen = scl & lvl_d[0] & lvl_d[1] & ~sda;
	assign stop_seen = scl & lvl_d[0] & ~lvl_d[1] & sda;
	// strap latch after reset release
	logic [1:0] strap_cnt_reg, strap_cnt_next;
	logic [1:0] strap_reg, strap_next;
	always_comb begin
		strap_cnt_next = strap_cnt_reg;
		strap_next = strap_reg;
		if (strap_cnt_reg != `STRAP_LATCH_CYCLES) begin
			strap_cnt_next = strap_cnt_reg + 2'h1;
			strap_next = lvl[11:10];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			strap_cnt_reg <= 2'h0;
			strap_reg <= 2'b00;
		end else begin
			strap_cnt_reg <= strap_cnt_next;
			strap_reg <= strap_next;
		end
	end
	// configuration registers
	logic [7:0] oe_reg, oe_next;
	logic src_reg, src_next;
	logic [1:0] sw_code_reg, sw_code_next;
	logic [1:0] amp_reg, amp_next;
	logic [7:0] edge_reg, edge_next;
	logic [1:0] ref_rate_reg, ref_rate_next;
	logic wol_reg, wol_next;
	logic ref_oe_reg, ref_oe_next;
	logic [4:0] len_reg, len_next;
	logic wr_en;
	logic [7:0] wr_idx, wr_data;
	function automatic logic [7:0] read_byte(input logic [7:0] idx);
		logic [7:0] val;
		val = 8'h00;
		unique case (idx)
			`IDX_OUTPUT_ENABLE: val = oe_reg;
			`IDX_SPREAD_AMP: val = {strap_reg, src_reg, sw_code_reg, `RSVD_B1_BIT2, amp_reg};
			`IDX_DIFF_EDGE: val = edge_reg;
			`IDX_REF_CTRL: val = {ref_rate_reg, wol_reg, ref_oe_reg, `RSVD_B3_LOW};
			`IDX_RESERVED: val = 8'h00;
			`IDX_REV_MAKER: val = {REVISION_CODE, MAKER_CODE};
			`IDX_TYPE_ID: val = {PART_TYPE, PART_IDENTIFIER};
			`IDX_READBACK_LEN: val = {3'b000, len_reg};
			default: val = 8'h00;
		endcase
		return val;
	endfunction : read_byte
	always_comb begin
		oe_next = oe_reg;
		src_next = src_reg;
		sw_code_next = sw_code_reg;
		amp_next = amp_reg;
		edge_next = edge_reg;
		ref_rate_next = ref_rate_reg;
		wol_next = wol_reg;
		ref_oe_next = ref_oe_reg;
		len_next = len_reg;
		if (wr_en) begin
			unique case (wr_idx)
				`IDX_OUTPUT_ENABLE: oe_next = wr_data;
				`IDX_SPREAD_AMP: begin
					src_next = wr_data[`POS_SPREAD_SRC];
					sw_code_next = wr_data[`POS_SW_CODE_HI:`POS_SW_CODE_LO];
					amp_next = wr_data[`POS_AMP_HI:`POS_AMP_LO];
				end
				`IDX_DIFF_EDGE: edge_next = wr_data;
				`IDX_REF_CTRL: begin
					ref_rate_next = wr_data[`POS_REF_RATE_HI:`POS_REF_RATE_LO];
					wol_next = wr_data[`POS_REF_WOL];
					ref_oe_next = wr_data[`POS_REF_OE];
				end
				`IDX_READBACK_LEN: len_next = wr_data[`POS_LEN_HI:0];
				default: oe_next = oe_reg;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			oe_reg <= `RST_OUTPUT_ENABLE;
			src_reg <= `RST_SPREAD_SRC;
			sw_code_reg <= `RST_SW_CODE;
			amp_reg <= `RST_AMP;
			edge_reg <= `RST_DIFF_EDGE;
			ref_rate_reg <= `RST_REF_RATE;
			wol_reg <= `RST_REF_WOL;
			ref_oe_reg <= `RST_REF_OE;
			len_reg <= `RST_READBACK_LEN;
		end else begin
			oe_reg <= oe_next;
			src_reg <= src_next;
			sw_code_reg <= sw_code_next;
			amp_reg <= amp_next;
			edge_reg <= edge_next;
			ref_rate_reg <= ref_rate_next;
			wol_reg <= wol_next;
			ref_oe_reg <= ref_oe_next;
			len_reg <= len_next;
		end
	end
	// output configuration
	clock_gen_pkg::clock_cfg_t cfg_next;
	logic [1:0] spread_code;
	always_comb begin
		spread_code = src_reg ? sw_code_reg : strap_reg;
		cfg_next.diff_clock_output_enable = oe_reg & ~lvl[9:2];
		cfg_next.diff_edge_rate_select = edge_reg;
		cfg_next.amplitude_sel = amp_reg;
		unique case (spread_code)
			2'b01: cfg_next.spread_mode = clock_gen_pkg::SPREAD_DOWN_025;
			2'b11: cfg_next.spread_mode = clock_gen_pkg::SPREAD_DOWN_050;
			default: cfg_next.spread_mode = clock_gen_pkg::SPREAD_OFF;
		endcase
		cfg_next.ref_edge_rate = ref_rate_reg;
		cfg_next.ref_wake_on_lan = wol_reg;
		cfg_next.ref_output_enable = ref_oe_reg;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clock_cfg <= '0;
		end else begin
			clock_cfg <= cfg_next;
		end
	end
	// bus slave
	clock_gen_pkg::bus_state_t state_reg, state_next, after_reg, after_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] index_reg, index_next;
	logic first_reg, first_next, nack_reg, nack_next, oe_n_reg, oe_n_next;
	logic [7:0] tx;
	always_comb begin
		state_next = state_reg;
		after_next = after_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		index_next = index_reg;
		first_next = first_reg;
		nack_next = nack_reg;
		oe_n_next = oe_n_reg;
		wr_en = 1'b0;
		wr_idx = index_reg;
		wr_data = shift_reg;
		tx = first_reg ? {3'b000, len_reg} : read_byte(index_reg);
		if (start_seen) begin
			state_next = clock_gen_pkg::ST_ADDR;
			bit_next = 4'h0;
			oe_n_next = 1'b1;
		end else if (stop_seen) begin
			state_next = clock_gen_pkg::ST_IDLE;
			oe_n_next = 1'b1;
		end else begin
			unique case (state_reg)
				clock_gen_pkg::ST_IDLE: oe_n_next = 1'b1;
				clock_gen_pkg::ST_ADDR, clock_gen_pkg::ST_CMD,
				clock_gen_pkg::ST_CNT, clock_gen_pkg::ST_WDATA: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda};
						bit_next = bit_reg + 4'h1;
					end else if (scl_fall && bit_reg == 4'h8) begin
						bit_next = 4'h0;
						oe_n_next = 1'b0;
						state_next = clock_gen_pkg::ST_ACK;
						if (state_reg == clock_gen_pkg::ST_ADDR) begin
							after_next = shift_reg[0] ? clock_gen_pkg::ST_RDATA
								: clock_gen_pkg::ST_CMD;
							first_next = 1'b1;
							if (shift_reg[7:1] != BUS_ADDR) begin
								oe_n_next = 1'b1;
								state_next = clock_gen_pkg::ST_IDLE;
							end
						end else if (state_reg == clock_gen_pkg::ST_CMD) begin
							index_next = shift_reg;
							after_next = clock_gen_pkg::ST_CNT;
						end else if (state_reg == clock_gen_pkg::ST_CNT) begin
							after_next = clock_gen_pkg::ST_WDATA;
						end else begin
							wr_en = 1'b1;
							index_next = index_reg + 8'h01;
							after_next = clock_gen_pkg::ST_WDATA;
						end
					end
				end
				clock_gen_pkg::ST_ACK, clock_gen_pkg::ST_RACK: begin
					if (scl_rise && state_reg == clock_gen_pkg::ST_RACK) begin
						nack_next = sda;
					end else if (scl_fall) begin
						oe_n_next = 1'b1;
						bit_next = 4'h0;
						state_next = after_reg;
						if (state_reg == clock_gen_pkg::ST_RACK && nack_reg) begin
							state_next = clock_gen_pkg::ST_IDLE;
						end else if (after_reg == clock_gen_pkg::ST_RDATA) begin
							shift_next = tx;
							oe_n_next = tx[7];
							bit_next = 4'h1;
							first_next = 1'b0;
							if (!first_reg) begin
								index_next = index_reg + 8'h01;
							end
						end
					end
				end
				clock_gen_pkg::ST_RDATA: begin
					if (scl_fall) begin
						if (bit_reg == 4'h8) begin
							oe_n_next = 1'b1;
							state_next = clock_gen_pkg::ST_RACK;
							nack_next = 1'b1;
						end else begin
							oe_n_next = shift_reg[6];
							shift_next = {shift_reg[6:0], 1'b1};
							bit_next = bit_reg + 4'h1;
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= clock_gen_pkg::ST_IDLE;
			after_reg <= clock_gen_pkg::ST_IDLE;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			index_reg <= 8'h00;
			first_reg <= 1'b0;
			nack_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			smb_data_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			after_reg <= after_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			index_reg <= index_next;
			first_reg <= first_next;
			nack_reg <= nack_next;
			oe_n_reg <= oe_n_next;
			smb_data_out <= 1'b0;
		end
	end
	assign smb_data_oe_n = oe_n_reg;
endmodule : clock_gen_smbus_control_regs

// *** include/clock_gen_defines.svh ***
`ifndef CLOCK_GEN_DEFINES_SVH
`define CLOCK_GEN_DEFINES_SVH

// register indexes
`define IDX_OUTPUT_ENABLE 8'h00
`define IDX_SPREAD_AMP 8'h01
`define IDX_DIFF_EDGE 8'h02
`define IDX_REF_CTRL 8'h03
`define IDX_RESERVED 8'h04
`define IDX_REV_MAKER 8'h05
`define IDX_TYPE_ID 8'h06
`define IDX_READBACK_LEN 8'h07

// field positions
`define POS_STRAP_HI 7
`define POS_STRAP_LO 6
`define POS_SPREAD_SRC 5
`define POS_SW_CODE_HI 4
`define POS_SW_CODE_LO 3
`define POS_AMP_HI 1
`define POS_AMP_LO 0
`define POS_REF_RATE_HI 7
`define POS_REF_RATE_LO 6
`define POS_REF_WOL 5
`define POS_REF_OE 4
`define POS_LEN_HI 4

// reset values
`define RST_OUTPUT_ENABLE 8'hff
`define RST_SPREAD_SRC 1'b0
`define RST_SW_CODE 2'b00
`define RST_AMP 2'b10
`define RST_DIFF_EDGE 8'hff
`define RST_REF_RATE 2'b01
`define RST_REF_WOL 1'b0
`define RST_REF_OE 1'b1
`define RST_READBACK_LEN 5'h08

// fixed read values of reserved bits
`define RSVD_B1_BIT2 1'b1
`define RSVD_B3_LOW 4'hf

// default bus address, cycles to wait before latching the strap
`define DEFAULT_BUS_ADDR 7'h68
`define STRAP_LATCH_CYCLES 2'h3

`endif

// *** include/clock_gen_pkg.sv ***
package clock_gen_pkg;

	typedef enum logic [1:0] {
		SPREAD_OFF = 2'b00,
		SPREAD_DOWN_025 = 2'b01,
		SPREAD_RESERVED = 2'b10,
		SPREAD_DOWN_050 = 2'b11
	} spread_mode_t;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_CMD = 8'h04,
		ST_CNT = 8'h08,
		ST_WDATA = 8'h10,
		ST_ACK = 8'h20,
		ST_RDATA = 8'h40,
		ST_RACK = 8'h80
	} bus_state_t;

	typedef struct packed {
		logic [7:0] diff_clock_output_enable;
		logic [7:0] diff_edge_rate_select;
		logic [1:0] amplitude_sel;
		spread_mode_t spread_mode;
		logic [1:0] ref_edge_rate;
		logic ref_wake_on_lan;
		logic ref_output_enable;
	} clock_cfg_t;

endpackage : clock_gen_pkg

// *** core/line_sync.sv ***
`timescale 1ns/1ps
module line_sync #(
	parameter int WIDTH = 12
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] level_d
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	if (WIDTH < 1) begin : g_width_check
		$error("line_sync WIDTH must be at least 1");
	end

	// two flops per line, then a third copy for edge finding
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta_reg <= '1;
			sync_reg <= '1;
			prev_reg <= '1;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign level_d = prev_reg;
endmodule : line_sync

// *** testbench/clock_gen_smbus_control_regs_assertions.sv ***
`timescale 1ns/1ps
module clock_gen_smbus_control_regs_assertions (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic smb_clk,
	input wire logic smb_data_in,
	input wire logic smb_data_out,
	input wire logic smb_data_oe_n,
	input wire logic [7:0] diff_oe_pin_n,
	input wire logic [1:0] spread_strap_level,
	input wire clock_gen_pkg::clock_cfg_t clock_cfg
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic [13:0] cfg_part;
	assign cfg_part = {clock_cfg.diff_edge_rate_select, clock_cfg.amplitude_sel,
		clock_cfg.ref_edge_rate, clock_cfg.ref_wake_on_lan, clock_cfg.ref_output_enable};
	open_drain_a: assert property (!smb_data_out)
		else $error("data output not held low");
	pin_gate_a: assert property ($stable(diff_oe_pin_n) [*5] |->
		(clock_cfg.diff_clock_output_enable & diff_oe_pin_n) == 8'h00)
		else $error("output enabled while its pin is high");
	spread_code_a: assert property (clock_cfg.spread_mode != clock_gen_pkg::SPREAD_RESERVED)
		else $error("reserved spread code reached the output");
	reset_values_a: assert property ($rose(rst_n) |-> ##[1:2] cfg_part == 14'h3fe5)
		else $error("configuration reset values wrong");
	cfg_cause_a: assert property ($past(rst_n, 3) && !$stable(cfg_part) |->
		$past(smb_data_oe_n, 3) && !$past(smb_data_oe_n))
		else $error("configuration changed without a write acknowledge");
	strap_latch_a: assert property ($past(rst_n, 8) && !$stable(clock_cfg.spread_mode) |->
		$past(smb_data_oe_n, 3) && !$past(smb_data_oe_n))
		else $error("spread mode changed without a write");
	oe_bounded_a: assert property ($fell(smb_data_oe_n) |-> ##[1:80] smb_data_oe_n)
		else $error("data line held low too long");
	oe_clock_low_a: assert property (!$stable(smb_data_oe_n) |-> !smb_clk)
		else $error("data line moved while clock high");
	cover property ($fell(smb_data_oe_n));
	cover property (!$stable(clock_cfg.spread_mode));
	cover property (clock_cfg.diff_clock_output_enable == 8'h30);
endmodule : clock_gen_smbus_control_regs_assertions

bind clock_gen_smbus_control_regs clock_gen_smbus_control_regs_assertions
	clock_gen_smbus_control_regs_assertions_i (.sys_clk(sys_clk), .rst_n(rst_n),
	.smb_clk(smb_clk), .smb_data_in(smb_data_in), .smb_data_out(smb_data_out),
	.smb_data_oe_n(smb_data_oe_n), .diff_oe_pin_n(diff_oe_pin_n),
	.spread_strap_level(spread_strap_level), .clock_cfg(clock_cfg));

// *** testbench/smb_host.sv ***
`timescale 1ns/1ps
module smb_host (
	input wire logic sys_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	// idle bus: clock stands high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wait_n
	task automatic clk_bit(input logic b, output logic s);
		wait_n(2);
		sda_drv = b;
		wait_n(2);
		scl = 1'b1;
		wait_n(4);
		s = sda_line;
		scl = 1'b0;
	endtask : clk_bit
	task automatic start_bit();
		wait_n(2);
		sda_drv = 1'b1;
		wait_n(2);
		scl = 1'b1;
		wait_n(4);
		sda_drv = 1'b0;
		wait_n(4);
		scl = 1'b0;
	endtask : start_bit
	task automatic stop_bit();
		wait_n(2);
		sda_drv = 1'b0;
		wait_n(2);
		scl = 1'b1;
		wait_n(4);
		sda_drv = 1'b1;
		wait_n(4);
	endtask : stop_bit
	// msb first, then the ninth bit: host ack or nack out, device ack in
	task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx,
		output logic ack_in);
		for (int i = 7; i >= 0; i--)
			clk_bit(tx[i], rx[i]);
		clk_bit(ack_out, ack_in);
	endtask : xfer
endmodule : smb_host

// *** testbench/tb_clock_gen_smbus_control_regs.sv ***
`timescale 1ns/1ps
module tb_clock_gen_smbus_control_regs;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] pins_n = 8'hff;
	logic [1:0] strap = 2'b01;
	logic scl, sda_drv, sda_out, sda_oe_n, ack;
	logic [7:0] rx;
	logic [1:0] c;
	int miscompares = 0;
	int num_checks = 0;
	clock_gen_pkg::clock_cfg_t cfg;
	wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
	wire logic [7:0] amp_sp = {4'h0, cfg.amplitude_sel, cfg.spread_mode};
	wire logic [7:0] ref_b = {cfg.ref_edge_rate, cfg.ref_wake_on_lan, cfg.ref_output_enable, 4'h0};
	clock_gen_smbus_control_regs clock_gen_smbus_control_regs_i (.sys_clk(sys_clk),
		.rst_n(rst_n), .smb_clk(scl), .smb_data_in(sda_line), .smb_data_out(sda_out),
		.smb_data_oe_n(sda_oe_n), .diff_oe_pin_n(pins_n), .spread_strap_level(strap),
		.clock_cfg(cfg));
	smb_host smb_host_i (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	initial forever #20 sys_clk = ~sys_clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tx(input logic [7:0] b);
		smb_host_i.xfer(b, 1'b1, rx, ack);
		check({7'h0, ack}, 8'h00);
	endtask : tx
	task automatic wr(input logic [7:0] idx, input logic [7:0] d [$]);
		smb_host_i.start_bit();
		tx(8'hd0);
		tx(idx);
		tx(8'(d.size()));
		foreach (d[i]) tx(d[i]);
		smb_host_i.stop_bit();
	endtask : wr
	// first expected byte is the count byte
	task automatic rd(input logic [7:0] idx, input logic [7:0] e [$]);
		smb_host_i.start_bit();
		tx(8'hd0);
		tx(idx);
		smb_host_i.start_bit();
		tx(8'hd1);
		foreach (e[i]) begin
			smb_host_i.xfer(8'hff, i == e.size() - 1, rx, ack);
			check(rx, e[i]);
		end
		smb_host_i.stop_bit();
	endtask : rd
	task automatic conclude();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	initial begin
		#2000000;
		miscompares++;
		conclude();
	end
	initial begin
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		pins_n = 8'h00;
		repeat (8) @(negedge sys_clk);
		strap = 2'b11;
		check(cfg.diff_edge_rate_select, 8'hff);
		check(ref_b, 8'h50);
		check(amp_sp, 8'h09);
		check(cfg.diff_clock_output_enable, 8'hff);
		$display("reset test done");
		rd(8'h01, '{8'h08, 8'h46, 8'hff, 8'h5f, 8'h00, 8'h39, 8'hd5, 8'h08});
		wr(8'h01, '{8'hff, 8'h5a, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff});
		check(cfg.diff_edge_rate_select, 8'h5a);
		check(ref_b, 8'h00);
		check(amp_sp, 8'h0f);
		rd(8'h01, '{8'h1f, 8'h7f, 8'h5a, 8'h0f, 8'h00, 8'h39, 8'hd5, 8'h1f});
		$display("block access test done");
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(8'h01, '{{3'b001, c, 1'b0, c}});
			check(amp_sp, {4'h0, c, c == 2'b10 ? 2'b00 : c});
		end
		wr(8'h01, '{8'h18});
		check(amp_sp, 8'h01);
		$display("spread test done");
		pins_n = 8'h0f;
		wr(8'h00, '{8'h3c});
		check(cfg.diff_clock_output_enable, 8'h30);
		smb_host_i.start_bit();
		smb_host_i.xfer(8'hd2, 1'b1, rx, ack);
		smb_host_i.stop_bit();
		check({7'h0, ack}, 8'h01);
		$display("enable and address test done");
		rst_n = 1'b0;
		strap = 2'b11;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (8) @(negedge sys_clk);
		strap = 2'b00;
		check(amp_sp, 8'h0b);
		rd(8'h01, '{8'h08, 8'hc6});
		$display("strap reset test done");
		conclude();
	end
endmodule : tb_clock_gen_smbus_control_regs
